// ### verilog/backlight_pkg.sv
// Package with register map, reset values, frame layout and timing constants.
package backlight_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 17;
  localparam logic [4:0] FRAME_BITS_W = 5'h11;
  localparam logic [4:0] DATA_FIRST_BIT = 5'h09;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WR_BRIGHT = 8'h51;
  localparam logic [7:0] CMD_RD_BRIGHT = 8'h52;
  localparam logic [7:0] CMD_WR_CTL = 8'h53;
  localparam logic [7:0] CMD_RD_CTL = 8'h54;
  localparam logic [7:0] CMD_ADAPT_MODE = 8'h82;
  localparam logic [7:0] CMD_WR_MIN = 8'h5E;
  localparam logic [7:0] CMD_RD_MIN = 8'h5F;
  localparam logic [7:0] CMD_PWM_DIV = 8'h60;
  localparam logic [7:0] CMD_THR_MS = 8'h61;
  localparam logic [7:0] CMD_THR_UI = 8'h62;
  localparam logic [7:0] CMD_DTH_MS = 8'h63;
  localparam logic [7:0] CMD_INTERFACE_DITHER = 8'h64;
  localparam logic [7:0] CMD_FADE = 8'h65;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BRIGHT = 8'hFF;
  localparam logic [7:0] RST_CTL = 8'h2C;
  localparam logic [7:0] RST_ADAPT = 8'h20;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_PWM_DIV = 8'h12;
  localparam logic [7:0] RST_THR_MS = 8'hB8;
  localparam logic [7:0] RST_THR_UI = 8'h04;
  localparam logic [7:0] RST_DTH_MS = 8'hC9;
  localparam logic [7:0] RST_INTERFACE_DITHER = 8'h04;
  localparam logic [7:0] RST_FADE = 8'h73;
  localparam int CTL_BLOCK_BIT = 5;
  localparam int CTL_DIM_BIT = 3;
  localparam int CTL_BL_BIT = 2;
  localparam logic [7:0] CTL_MASK = 8'h2C;
  localparam logic [7:0] ADAPT_MASK = 8'h30;
  localparam int ADAPT_LSB = 4;

  // ---------------------------------------------------------------
  // Timing: PWM base clock of 6 MHz from 20 MHz system clock
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int PWM_BASE_HZ = 6_000_000;
  localparam logic [7:0] PWM_PERIOD_STEPS = 8'hFF;
  localparam int DIM_STEP_US = 20;
  localparam int DIM_STEP_CYC = DIM_STEP_US * (SYS_CLK_HZ / 1_000_000);

  typedef enum {ADAPT_OFF, ADAPT_UI, ADAPT_STILL, ADAPT_MOVING} adapt_mode_t;

  typedef struct packed {
    logic dc;
    logic rw;
    logic [7:0] code;
  } frame_head_t;

  typedef struct packed {
    logic block_on;
    logic dim_en;
    logic bl_on;
  } ctl_bits_t;

endpackage

// ### verilog/backlight_pwm.sv
// PWM generator: 6 MHz fractional step, divider prescale, 255-step period.
`timescale 1ns/10ps
`default_nettype none
module backlight_pwm
  import backlight_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] divider_i,
  input wire logic [7:0] duty_i,
  output logic pwm_o
);

  logic [4:0] acc;
  logic [4:0] next_acc;
  logic [7:0] pre;
  logic [7:0] next_pre;
  logic [7:0] phase;
  logic [7:0] next_phase;
  logic next_pwm;
  logic base_tick;
  logic step;

  // ---------------------------------------------------------------
  // Step generation
  // ---------------------------------------------------------------
  // Accumulator yields 3 ticks per 10 cycles, an average of 6 MHz.
  always_comb begin
    base_tick = (acc >= 5'h07);
    if (base_tick) begin
      next_acc = acc - 5'h07;
    end else begin
      next_acc = acc + 5'h03;
    end
    // Comparing with >= lets a smaller divider take effect at once.
    step = base_tick && (pre >= divider_i);
    next_pre = pre;
    if (base_tick) begin
      next_pre = step ? 8'h00 : pre + 8'h01;
    end
    next_phase = phase;
    if (step) begin
      next_phase = (phase == PWM_PERIOD_STEPS - 8'h01) ? 8'h00 :
        phase + 8'h01;
    end
    next_pwm = (phase < duty_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= 5'h00;
      pre <= 8'h00;
      phase <= 8'h00;
      pwm_o <= 1'b0;
    end else begin
      acc <= next_acc;
      pre <= next_pre;
      phase <= next_phase;
      pwm_o <= next_pwm;
    end
  end

endmodule
`default_nettype wire

// ### verilog/backlight_cmd_regs.sv
// Three-wire serial command engine with brightness register set.
`timescale 1ns/10ps
`default_nettype none
module backlight_cmd_regs
  import backlight_pkg::*;
#(
  parameter int DIM_CYCLES = DIM_STEP_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_line_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  output logic backlight_pwm_out_o
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sck_d;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sck_d <= 1'b1;
    end else begin
      sync_a <= {chip_select_n_i, serial_clock_line_i, serial_data_line_i};
      sync_b <= sync_a;
      sck_d <= sync_b[1];
    end
  end

  logic cs_n;
  logic sck;
  logic sdi;
  logic sck_rise;
  logic sck_fall;
  assign cs_n = sync_b[2];
  assign sck = sync_b[1];
  assign sdi = sync_b[0];
  assign sck_rise = sck && !sck_d && !cs_n;
  assign sck_fall = !sck && sck_d && !cs_n;

  // ---------------------------------------------------------------
  // Frame receiver
  // ---------------------------------------------------------------
  typedef enum {FR_IDLE, FR_HEAD, FR_DATA, FR_OVER} frame_st_t;

  frame_st_t st;
  frame_st_t next_st;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [16:0] shift;
  logic [16:0] next_shift;
  logic [7:0] rd_shift;
  logic [7:0] next_rd_shift;
  logic drive;
  logic next_drive;
  logic sdo;
  logic next_sdo;
  logic cs_n_d;
  logic commit;
  logic [7:0] rd_value;
  frame_head_t head;
  frame_head_t next_head;

  always_comb begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_rd_shift = rd_shift;
    next_drive = drive;
    next_sdo = sdo;
    next_head = head;
    if (cs_n) begin
      next_st = FR_IDLE;
      next_bit_cnt = 5'h00;
      next_drive = 1'b0;
    end else begin
      case (st)
        FR_IDLE: begin
          next_st = FR_HEAD;
        end
        FR_HEAD, FR_DATA: begin
          if (sck_rise) begin
            next_shift = {shift[15:0], sdi};
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt + 5'h01 == DATA_FIRST_BIT) begin
              next_st = FR_DATA;
              next_head = '{dc: 1'b0, rw: shift[7], code: {shift[6:0], sdi}};
            end
            if (bit_cnt + 5'h01 > FRAME_BITS_W) begin
              next_st = FR_OVER;
            end
          end
          // Read data changes on the falling edge for rising capture.
          if (sck_fall && st == FR_DATA && head.rw) begin
            next_drive = 1'b1;
            if (drive) begin
              next_sdo = rd_shift[7];
              next_rd_shift = {rd_shift[6:0], 1'b0};
            end else begin
              next_sdo = rd_value[7];
              next_rd_shift = {rd_value[6:0], 1'b0};
            end
          end
          if (bit_cnt >= FRAME_BITS_W) begin
            next_drive = 1'b0;
          end
        end
        FR_OVER: begin
          next_drive = 1'b0;
        end
        default: begin
          next_st = FR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= FR_IDLE;
      bit_cnt <= 5'h00;
      shift <= 17'h00000;
      rd_shift <= 8'h00;
      drive <= 1'b0;
      sdo <= 1'b0;
      head <= '0;
      cs_n_d <= 1'b1;
    end else begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      rd_shift <= next_rd_shift;
      drive <= next_drive;
      sdo <= next_sdo;
      head <= next_head;
      cs_n_d <= cs_n;
    end
  end

  // Write commits at select release only for a full frame.
  // Layout: direction bit, command byte, parameter byte, all MSB first.
  // A read frame never commits, so the line in its release phase is ignored.
  logic [7:0] wr_code;
  logic [7:0] wr_data;
  logic wr_ok;
  assign wr_code = head.code;
  assign wr_data = shift[7:0];
  assign wr_ok = !head.rw && !head.dc;
  assign commit = cs_n && !cs_n_d && (bit_cnt == FRAME_BITS_W) && wr_ok;

  assign serial_data_line_o = sdo;
  assign serial_data_line_oe_o = drive;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] regs [0:9];
  logic [7:0] next_regs [0:9];
  localparam logic [7:0] REG_CODE [0:9] = '{CMD_WR_BRIGHT, CMD_WR_CTL,
    CMD_ADAPT_MODE, CMD_WR_MIN, CMD_PWM_DIV, CMD_THR_MS, CMD_THR_UI,
    CMD_DTH_MS, CMD_INTERFACE_DITHER, CMD_FADE};
  localparam logic [7:0] REG_RST [0:9] = '{RST_BRIGHT, RST_CTL, RST_ADAPT,
    RST_MIN, RST_PWM_DIV, RST_THR_MS, RST_THR_UI, RST_DTH_MS, RST_INTERFACE_DITHER,
    RST_FADE};
  localparam logic [7:0] REG_MASK [0:9] = '{8'hFF, CTL_MASK, ADAPT_MASK,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (commit && wr_code == REG_CODE[gi]) begin
          next_regs[gi] = wr_data & REG_MASK[gi];
        end
      end
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs[gi] <= REG_RST[gi];
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  ctl_bits_t ctl;
  adapt_mode_t mode;
  assign ctl = '{block_on: regs[1][CTL_BLOCK_BIT],
    dim_en: regs[1][CTL_DIM_BIT], bl_on: regs[1][CTL_BL_BIT]};
  assign mode = adapt_mode_t'(regs[2][ADAPT_LSB +: 2]);

  // Adaptive level: no content analysis here, floor clamps manual value.
  logic [7:0] target;
  always_comb begin
    if (!ctl.block_on) begin
      target = 8'h00;
    end else if (mode != ADAPT_OFF && regs[0] < regs[3]) begin
      target = regs[3];
    end else begin
      target = regs[0];
    end
  end

  always_comb begin
    case (head.code)
      CMD_RD_BRIGHT: rd_value = ctl.block_on ? target : 8'h00;
      CMD_RD_CTL: rd_value = regs[1];
      CMD_ADAPT_MODE: rd_value = regs[2];
      CMD_RD_MIN: rd_value = regs[3];
      default: rd_value = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Dimming ramp
  // ---------------------------------------------------------------
  logic [7:0] level;
  logic [7:0] next_level;
  logic ramping;
  logic next_ramping;
  logic block_d;
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic tick;
  logic [7:0] duty;

  assign tick = (tick_cnt == 16'(DIM_CYCLES - 1));

  always_comb begin
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_ramping = ramping;
    next_level = level;
    // Holding the level on the toggle cycle keeps the ramp from its start.
    if (ctl.block_on != block_d && ctl.dim_en && mode == ADAPT_OFF) begin
      next_ramping = 1'b1;
    end else if (!ramping) begin
      next_level = target;
    end else if (tick) begin
      if (level < target) begin
        next_level = level + 8'h01;
      end else if (level > target) begin
        next_level = level - 8'h01;
      end else begin
        next_ramping = 1'b0;
      end
    end
    duty = ctl.bl_on ? level : 8'h00;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level <= RST_BRIGHT;
      ramping <= 1'b0;
      block_d <= 1'b1;
      tick_cnt <= 16'h0000;
    end else begin
      level <= next_level;
      ramping <= next_ramping;
      block_d <= ctl.block_on;
      tick_cnt <= next_tick_cnt;
    end
  end

  backlight_pwm u_pwm (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .divider_i(regs[4]),
    .duty_i(duty),
    .pwm_o(backlight_pwm_out_o)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_release;
    cs_n && !cs_n_d;
  endsequence

  AST_SHORT_DROPPED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_release and (bit_cnt != FRAME_BITS_W) |=> $stable(regs[0]))
    else $error("short frame changed brightness");
  AST_CS_RESETS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cs_n |=> (bit_cnt == 5'h00) && !drive)
    else $error("frame state not cleared");
  AST_NO_DRIVE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    drive |-> head.rw)
    else $error("drive during write");
  AST_BLOCK_OFF_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctl.block_on |-> target == 8'h00)
    else $error("block off not zero");
  AST_RD_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctl.block_on && head.code == CMD_RD_BRIGHT |-> rd_value == 8'h00)
    else $error("readback not zero");
  AST_BL_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctl.bl_on |=> !backlight_pwm_out_o)
    else $error("backlight not off");
  AST_WRITE_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    commit && wr_code == CMD_WR_BRIGHT |=> regs[0] == $past(wr_data))
    else $error("brightness not loaded");
  AST_FLOOR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ctl.block_on && mode != ADAPT_OFF |-> target >= regs[3])
    else $error("below floor");

endmodule
`default_nettype wire

// ### verification/host_port_model.sv
// Host controller model that drives the three-wire serial port.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input wire logic sys_clk_i,
  input wire logic dev_data_i,
  input wire logic dev_oe_i,
  output logic chip_select_n_o,
  output logic serial_clock_line_o,
  output logic serial_data_line_o
);
  logic host_oe;
  logic host_data;
  logic last_level;

  // An undriven line shows the inverse of its last level, never a stale copy.
  assign serial_data_line_o = dev_oe_i ? dev_data_i :
    (host_oe ? host_data : ~last_level);

  initial begin
    chip_select_n_o = 1'b1;
    serial_clock_line_o = 1'b1;
    host_oe = 1'b0;
    host_data = 1'b0;
    last_level = 1'b0;
  end

  always @(negedge sys_clk_i) begin
    if (host_oe || dev_oe_i) begin
      last_level <= serial_data_line_o;
    end
  end

  // ---------------------------------------------------------------
  // One frame: direction, code and data, most significant bit first.
  // ---------------------------------------------------------------
  task automatic frame(input logic rd, input logic [7:0] code,
      input logic [7:0] data, input int nbits, input int half,
      output logic [7:0] rdata);
    logic [16:0] word;
    word = {rd, code, data};
    rdata = 8'h00;
    @(negedge sys_clk_i);
    chip_select_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_clock_line_o = 1'b0;
      host_oe = !(rd && i >= 9);
      host_data = (i < 17) ? word[16 - i] : 1'b0;
      repeat (half) @(negedge sys_clk_i);
      serial_clock_line_o = 1'b1;
      if (rd && i >= 9) begin
        rdata = {rdata[6:0], serial_data_line_o};
      end
      repeat (half) @(negedge sys_clk_i);
    end
    host_oe = 1'b0;
    chip_select_n_o = 1'b1;
    repeat (8) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ### verification/serial_backlight_command_regs_test.sv
// Self-checking testbench of the serial backlight command engine.
`timescale 1ns/10ps
`default_nettype none
module serial_backlight_command_regs_test;
  import backlight_pkg::*;
  logic sys_clk, rst_n, cs_n, sclk, sdl, dev_d, dev_oe, pwm;
  int n_mismatch, checked, seed, hi, hi2, rises;
  int bad[3] = '{16, 18, 1};
  logic [7:0] rd, v, w, m;

  backlight_cmd_regs #(.DIM_CYCLES(4)) u_backlight_cmd_regs (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .chip_select_n_i(cs_n),
    .serial_clock_line_i(sclk), .serial_data_line_i(sdl),
    .serial_data_line_o(dev_d), .serial_data_line_oe_o(dev_oe),
    .backlight_pwm_out_o(pwm));
  host_port_model u_host_port_model (
    .sys_clk_i(sys_clk), .dev_data_i(dev_d), .dev_oe_i(dev_oe),
    .chip_select_n_o(cs_n), .serial_clock_line_o(sclk),
    .serial_data_line_o(sdl));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    logic [7:0] unused;
    u_host_port_model.frame(1'b0, code, d, FRAME_BITS, 4, unused);
  endtask
  // Reads are taken at the nominal rate or at half of it, at random.
  task automatic rdreg(input logic [7:0] code, output logic [7:0] d);
    int half;
    half = 4 + 4 * ($random(seed) & 1);
    u_host_port_model.frame(1'b1, code, 8'h00, FRAME_BITS, half, d);
  endtask
  // Two full PWM periods at divider zero: 2 * 850 clock cycles.
  task automatic measure(output int high, output int edges);
    logic prev;
    high = 0;
    edges = 0;
    prev = pwm;
    repeat (1700) begin
      @(negedge sys_clk);
      if (pwm === 1'b1) high++;
      if (pwm === 1'b1 && prev === 1'b0) edges++;
      prev = pwm;
    end
  endtask
  function automatic logic near(input int high, input logic [7:0] d);
    int e;
    e = 1700 * d / 255;
    return (high >= e - 40) && (high <= e + 40);
  endfunction
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h751D568F;
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rdreg(CMD_RD_BRIGHT, rd);
    check(rd, RST_BRIGHT);
    rdreg(CMD_RD_CTL, rd);
    check(rd, RST_CTL);
    rdreg(CMD_ADAPT_MODE, rd);
    check(rd, RST_ADAPT);
    rdreg(CMD_RD_MIN, rd);
    check(rd, RST_MIN);
    for (int k = 0; k < 8; k++) begin
      wr(CMD_WR_CTL, 8'h24);
      v = $random(seed);
      w = $random(seed);
      m = (w & ~ADAPT_MASK) | {2'b00, k[1:0], 4'h0};
      wr(CMD_WR_BRIGHT, v);
      rdreg(CMD_RD_BRIGHT, rd);
      check(rd, v);
      wr(CMD_WR_MIN, w);
      rdreg(CMD_RD_MIN, rd);
      check(rd, w);
      wr(CMD_ADAPT_MODE, m);
      rdreg(CMD_ADAPT_MODE, rd);
      check(rd, {2'b00, k[1:0], 4'h0});
      wr(CMD_ADAPT_MODE, 8'h00);
      wr(CMD_WR_CTL, w | 8'h24);
      rdreg(CMD_RD_CTL, rd);
      check(rd, (w | 8'h24) & CTL_MASK);
      wr(CMD_THR_MS + 8'(k % 5), v);
    end
    wr(CMD_WR_CTL, 8'h24);
    wr(CMD_WR_BRIGHT, 8'h3C);
    foreach (bad[i]) begin
      u_host_port_model.frame(1'b0, CMD_WR_BRIGHT, 8'hC3, bad[i], 4, rd);
    end
    rdreg(CMD_RD_BRIGHT, rd);
    check(rd, 8'h3C);
    wr(CMD_PWM_DIV, 8'h00);
    wr(CMD_WR_BRIGHT, 8'h80);
    measure(hi, rises);
    check({7'h00, near(hi, 8'h80)}, 8'h01);
    check(8'(rises), 8'h02);
    wr(CMD_WR_CTL, 8'h04);
    rdreg(CMD_RD_BRIGHT, rd);
    check(rd, 8'h00);
    measure(hi, rises);
    check(8'(hi), 8'h00);
    wr(CMD_WR_CTL, 8'h2C);
    measure(hi, rises);
    measure(hi2, rises);
    check({7'h00, hi < hi2}, 8'h01);
    check({7'h00, near(hi2, 8'h80)}, 8'h01);
    wr(CMD_WR_CTL, 8'h28);
    measure(hi, rises);
    check(8'(hi), 8'h00);
    wr(CMD_WR_CTL, 8'h24);
    wr(CMD_WR_BRIGHT, 8'h10);
    wr(CMD_WR_MIN, 8'h80);
    wr(CMD_ADAPT_MODE, 8'h10);
    measure(hi, rises);
    measure(hi, rises);
    check({7'h00, near(hi, 8'h80)}, 8'h01);
    wr(CMD_WR_CTL, 8'h04);
    measure(hi, rises);
    check(8'(hi), 8'h00);
    wr(CMD_WR_CTL, 8'h2C);
    measure(hi, rises);
    check({7'h00, near(hi, 8'h80)}, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
